/* File: hw/pwmp_counter.v */
// Prescaler and period counter of one PWM channel, with the active period shadow.
// Assumes module_en, div_sel and period inputs come from registers on the same clock.
`include "pwmp_defines.vh"

module pwmp_counter #(
    parameter W = `PWMP_CNT_W
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_b,
    // Control
    input  wire         module_en,
    input  wire [1:0]   clock_div_sel,
    input  wire [W-1:0] period_in,
    input  wire         period_pend,
    // State
    output reg  [W-1:0] cnt,
    output wire         start,
    output wire         wrap
);

    reg         en_d;
    reg [6:0]   pre;
    reg [W-1:0] period_act;
    reg [6:0]   lim;
    wire        tick;

    always @* begin
        case (clock_div_sel)
            2'b00:   lim = `PWMP_DIV1_LIM;
            2'b01:   lim = `PWMP_DIV8_LIM;
            2'b10:   lim = `PWMP_DIV32_LIM;
            default: lim = `PWMP_DIV128_LIM;
        endcase
    end

    assign start = module_en & ~en_d;
    // Compare with >= so a smaller divider chosen mid-count does not run the prescaler round
    assign tick  = module_en & ~start & (pre >= lim);
    assign wrap  = tick & (cnt >= period_act);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_d       <= 1'b0;
            pre        <= 7'h00;
            cnt        <= {W{1'b0}};
            period_act <= {W{1'b0}};
        end else begin
            en_d <= module_en;
            if (!module_en) begin
                pre <= 7'h00;
                cnt <= {W{1'b0}};
            end else if (start) begin
                pre        <= 7'h00;
                cnt        <= {{(W-1){1'b0}}, 1'b1};
                period_act <= period_in;
            end else if (tick) begin
                pre <= 7'h00;
                if (wrap) begin
                    cnt <= {{(W-1){1'b0}}, 1'b1};
                    if (period_pend)
                        period_act <= period_in;
                end else begin
                    cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
                end
            end else begin
                pre <= pre + 7'h01;
            end
        end
    end

endmodule

/* File: hw/pwmp_defines.vh */
// Constants for the three-channel PWM pair generator: register map, fields, dividers.
// Assumes inclusion by bare name from the design files only.
`ifndef PWMP_DEFINES_VH
`define PWMP_DEFINES_VH

`define PWMP_CHANNELS      3
`define PWMP_CNT_W         12
`define PWMP_ADDR_W        8

// Channel window stride in bytes, then register word indices inside one channel window
`define PWMP_CH_STRIDE     8'h20
`define PWMP_IDX_ENCFG     3'h0
`define PWMP_IDX_CTRL      3'h1
`define PWMP_IDX_PER_LO    3'h2
`define PWMP_IDX_PER_HI    3'h3
`define PWMP_IDX_DUTY_LO   3'h4
`define PWMP_IDX_DUTY_HI   3'h5
`define PWMP_IDX_DEAD_LO   3'h6
`define PWMP_IDX_DEAD_HI   3'h7

// Enable and fault configuration fields
`define PWMP_EN_MODULE     0
`define PWMP_EN_PRIMARY    1
`define PWMP_EN_SECONDARY  2
`define PWMP_EN_MODE       3
`define PWMP_EN_FAULT_DET  4
`define PWMP_EN_FLVL_LO    5
`define PWMP_EN_FLVL_HI    6
`define PWMP_ENCFG_MASK    8'h7f

// Control and status fields
`define PWMP_CT_DIV_LO     0
`define PWMP_CT_DIV_HI     1
`define PWMP_CT_POL_LO     2
`define PWMP_CT_POL_HI     3
`define PWMP_CT_FAULT_POL  4
`define PWMP_CT_FAULT_ST   5
`define PWMP_CT_OVF_FLAG   6
`define PWMP_CT_IRQ_EN     7

`define PWMP_RESET_BYTE    8'h00

// Prescaler terminal counts for divide by 1, 8, 32, 128
`define PWMP_DIV1_LIM      7'h00
`define PWMP_DIV8_LIM      7'h07
`define PWMP_DIV32_LIM     7'h1f
`define PWMP_DIV128_LIM    7'h7f

`endif

/* File: hw/pwmp_top.v */
// Three PWM pair channels with dead time, fault shutdown and an APB register slave.
// Assumes APB master on MCLK; fault pins are asynchronous and are synchronised here.
//
// Our own choices: register access over APB and the placing of the registers.
`include "pwmp_defines.vh"

module pwmp_top #(
    parameter NCH = `PWMP_CHANNELS,
    parameter W   = `PWMP_CNT_W
) (
    // Clock and reset
    input  wire                     MCLK,
    input  wire                     RST_B,
    // APB slave
    input  wire                     PSEL,
    input  wire                     PENABLE,
    input  wire                     PWRITE,
    input  wire [`PWMP_ADDR_W-1:0]  PADDR,
    input  wire [31:0]              PWDATA,
    input  wire [3:0]               PSTRB,
    output reg                      PREADY,
    output reg  [31:0]              PRDATA,
    output reg                      PSLVERR,
    // Fault pins
    input  wire [NCH-1:0]           FAULT_PIN,
    // Outputs
    output wire [NCH-1:0]           PRIMARY_OUT,
    output wire [NCH-1:0]           SECONDARY_OUT,
    output reg                      PWM_IRQ
);

    // Decode an APB address into {valid, channel, register index}
    function [5:0] dec;
        input [`PWMP_ADDR_W-1:0] a;
        reg [1:0] ch;
        begin
            ch  = a[6:5];
            dec = {(a[7] == 1'b0) && (ch < NCH) && (a[1:0] == 2'b00), ch, a[4:2]};
        end
    endfunction

    reg  [NCH-1:0]   fault_s1;
    reg  [NCH-1:0]   fault_s2;
    wire [5:0]       rd_dec;
    wire [5:0]       wr_dec;
    wire             wr_go;
    wire [7:0]       wr_byte;
    wire [NCH*64-1:0] rd_bus;
    wire [NCH-1:0]   irq_req;
    reg  [7:0]       rd_byte;

    assign rd_dec  = dec(PADDR);
    assign wr_dec  = dec(PADDR);
    assign wr_go   = PSEL & PENABLE & PREADY & PWRITE & wr_dec[5] & PSTRB[0];
    assign wr_byte = PWDATA[7:0];

    always @* begin
        rd_byte = 8'h00;
        if (rd_dec[5])
            rd_byte = rd_bus[{rd_dec[4:0], 3'b000} +: 8];
    end

    // Zero wait states: the access phase completes in its first cycle
    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL & ~PENABLE;
            if (PSEL & ~PENABLE) begin
                PRDATA  <= {24'h00_0000, rd_byte};
                PSLVERR <= ~rd_dec[5];
            end
        end
    end

    // Fault pins cross in from outside the clock domain
    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            fault_s1 <= {NCH{1'b0}};
            fault_s2 <= {NCH{1'b0}};
        end else begin
            fault_s1 <= FAULT_PIN;
            fault_s2 <= fault_s1;
        end
    end

    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B)
            PWM_IRQ <= 1'b0;
        else
            PWM_IRQ <= |irq_req;
    end

    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            reg  [7:0]   en_cfg;
            reg  [7:0]   ctrl;
            reg  [7:0]   per_lo;
            reg  [3:0]   per_hi;
            reg  [7:0]   duty_lo;
            reg  [3:0]   duty_hi;
            reg  [7:0]   dead_lo;
            reg  [3:0]   dead_hi;
            reg          per_pend;
            reg          duty_pend;
            reg          dead_pend;
            reg  [W-1:0] duty_act;
            reg  [W-1:0] dead_act;
            reg          pri_q;
            reg          sec_q;
            reg          pri_act;
            reg          sec_act;
            reg          next_pri;
            reg          next_sec;
            wire [W-1:0] cnt;
            wire         start;
            wire         wrap;
            wire         sel;
            wire         fault_act;
            wire         mod_en;
            wire         indep;
            wire [W:0]   duty_dead;

            assign sel       = wr_go && (wr_dec[4:3] == i);
            assign mod_en    = en_cfg[`PWMP_EN_MODULE];
            assign indep     = en_cfg[`PWMP_EN_MODE];
            // Pin level equal to the polarity bit means fault
            assign fault_act = en_cfg[`PWMP_EN_FAULT_DET] &&
                               (fault_s2[i] == ctrl[`PWMP_CT_FAULT_POL]);
            assign duty_dead = {1'b0, duty_act} + {1'b0, dead_act};

            pwmp_counter #(
                .W             (W)
            ) u_cnt (
                .clk           (MCLK),
                .rst_b         (RST_B),
                .module_en     (mod_en),
                .clock_div_sel (ctrl[`PWMP_CT_DIV_HI:`PWMP_CT_DIV_LO]),
                .period_in     ({per_hi, per_lo}),
                .period_pend   (per_pend),
                .cnt           (cnt),
                .start         (start),
                .wrap          (wrap)
            );

            always @(posedge MCLK or negedge RST_B) begin
                if (!RST_B) begin
                    en_cfg    <= `PWMP_RESET_BYTE;
                    ctrl      <= `PWMP_RESET_BYTE;
                    per_lo    <= `PWMP_RESET_BYTE;
                    per_hi    <= 4'h0;
                    duty_lo   <= `PWMP_RESET_BYTE;
                    duty_hi   <= 4'h0;
                    dead_lo   <= `PWMP_RESET_BYTE;
                    dead_hi   <= 4'h0;
                    per_pend  <= 1'b0;
                    duty_pend <= 1'b0;
                    dead_pend <= 1'b0;
                    duty_act  <= {W{1'b0}};
                    dead_act  <= {W{1'b0}};
                end else begin
                    if (sel && wr_dec[2:0] == `PWMP_IDX_ENCFG)
                        en_cfg <= wr_byte & `PWMP_ENCFG_MASK;
                    if (sel && wr_dec[2:0] == `PWMP_IDX_CTRL) begin
                        ctrl[`PWMP_CT_IRQ_EN] <= wr_byte[`PWMP_CT_IRQ_EN];
                        ctrl[`PWMP_CT_FAULT_POL:`PWMP_CT_DIV_LO] <=
                            wr_byte[`PWMP_CT_FAULT_POL:`PWMP_CT_DIV_LO];
                    end
                    // Set wins over a clear in the same cycle
                    if (wrap)
                        ctrl[`PWMP_CT_OVF_FLAG] <= 1'b1;
                    else if (sel && wr_dec[2:0] == `PWMP_IDX_CTRL &&
                             !wr_byte[`PWMP_CT_OVF_FLAG])
                        ctrl[`PWMP_CT_OVF_FLAG] <= 1'b0;
                    if (fault_act)
                        ctrl[`PWMP_CT_FAULT_ST] <= 1'b1;
                    else if (sel && wr_dec[2:0] == `PWMP_IDX_CTRL &&
                             !wr_byte[`PWMP_CT_FAULT_ST])
                        ctrl[`PWMP_CT_FAULT_ST] <= 1'b0;
                    if (sel && wr_dec[2:0] == `PWMP_IDX_PER_HI)
                        per_hi <= wr_byte[3:0];
                    if (sel && wr_dec[2:0] == `PWMP_IDX_DUTY_HI)
                        duty_hi <= wr_byte[3:0];
                    if (sel && wr_dec[2:0] == `PWMP_IDX_DEAD_HI)
                        dead_hi <= wr_byte[3:0];
                    // Low byte commits the value; it is taken at the next boundary
                    if (sel && wr_dec[2:0] == `PWMP_IDX_PER_LO) begin
                        per_lo   <= wr_byte;
                        per_pend <= 1'b1;
                    end else if (wrap || start) begin
                        per_pend <= 1'b0;
                    end
                    if (sel && wr_dec[2:0] == `PWMP_IDX_DUTY_LO) begin
                        duty_lo   <= wr_byte;
                        duty_pend <= 1'b1;
                    end else if (wrap || start) begin
                        duty_pend <= 1'b0;
                    end
                    if (sel && wr_dec[2:0] == `PWMP_IDX_DEAD_LO) begin
                        dead_lo   <= wr_byte;
                        dead_pend <= 1'b1;
                    end else if (wrap || start) begin
                        dead_pend <= 1'b0;
                    end
                    if (start || (wrap && duty_pend))
                        duty_act <= {duty_hi, duty_lo};
                    if (start || (wrap && dead_pend))
                        dead_act <= {dead_hi, dead_lo};
                end
            end

            // Active intervals; counter runs 1..period
            always @* begin
                if (indep) begin
                    pri_act = (cnt != {W{1'b0}}) && (cnt <= duty_act);
                    sec_act = (cnt != {W{1'b0}}) && (cnt <= dead_act);
                end else begin
                    // Dead time opens each active interval with both outputs idle
                    pri_act = (cnt > dead_act) && (cnt <= duty_act);
                    sec_act = ({1'b0, cnt} > duty_dead);
                end
            end

            // Disabled outputs sit low whatever the polarity, like an idle pin
            always @* begin
                next_pri = 1'b0;
                next_sec = 1'b0;
                if (mod_en) begin
                    if (ctrl[`PWMP_CT_FAULT_ST]) begin
                        next_pri = en_cfg[`PWMP_EN_FLVL_HI];
                        next_sec = en_cfg[`PWMP_EN_FLVL_LO];
                    end else begin
                        next_pri = pri_act ^ ctrl[`PWMP_CT_POL_HI];
                        next_sec = sec_act ^ ctrl[`PWMP_CT_POL_LO];
                    end
                    if (!en_cfg[`PWMP_EN_PRIMARY])
                        next_pri = 1'b0;
                    if (!en_cfg[`PWMP_EN_SECONDARY])
                        next_sec = 1'b0;
                end
            end

            always @(posedge MCLK or negedge RST_B) begin
                if (!RST_B) begin
                    pri_q <= 1'b0;
                    sec_q <= 1'b0;
                end else begin
                    pri_q <= next_pri;
                    sec_q <= next_sec;
                end
            end

            assign PRIMARY_OUT[i]   = pri_q;
            assign SECONDARY_OUT[i] = sec_q;
            assign irq_req[i]       = ctrl[`PWMP_CT_IRQ_EN] & ctrl[`PWMP_CT_OVF_FLAG];
            assign rd_bus[i*64 +: 64] = {4'h0, dead_hi, dead_lo, 4'h0, duty_hi, duty_lo,
                                         4'h0, per_hi, per_lo, ctrl, en_cfg};
        end
    endgenerate

endmodule

/* File: verif/pwmp_stage_model.sv */
// Power stage model: counts high cycles of channel 0 outputs and drives the fault pins.
// Assumes the bench sets fault_on and act_hi by non-blocking assignment after an edge.
module pwmp_stage_model (
    // Clock
    input  logic       clk,
    // Pair outputs
    input  logic [2:0] primary,
    input  logic [2:0] secondary,
    // Fault commands
    input  logic [2:0] fault_on,
    input  logic [2:0] act_hi,
    // Fault pins and counts
    output logic [2:0] fault_pin,
    output int         pri_hi,
    output int         sec_hi
);
    timeunit 1ns;
    timeprecision 100ps;
    // An idle pin sits at the inverse of its active level, never floating
    assign fault_pin = ~(fault_on ^ act_hi);
    initial begin
        pri_hi = 0;
        sec_hi = 0;
    end
    always @(posedge clk) begin
        pri_hi <= pri_hi + int'(primary[0] === 1'b1);
        sec_hi <= sec_hi + int'(secondary[0] === 1'b1);
    end
endmodule

/* File: verif/pwmp_top_properties.sv */
// Concurrent checks on the PWM pair top: APB answer, gating, fault levels, dead band.
// Assumes binding to pwmp_top; it mirrors the config and control writes itself.
module pwmp_top_properties #(
    parameter NCH = 3,
    parameter W   = 12
) (
    // Clock and reset
    input  logic           MCLK,
    input  logic           RST_B,
    // APB
    input  logic           PSEL,
    input  logic           PENABLE,
    input  logic           PWRITE,
    input  logic [7:0]     PADDR,
    input  logic [31:0]    PWDATA,
    input  logic [3:0]     PSTRB,
    input  logic           PREADY,
    input  logic [31:0]    PRDATA,
    input  logic           PSLVERR,
    // Pins
    input  logic [NCH-1:0] FAULT_PIN,
    input  logic [NCH-1:0] PRIMARY_OUT,
    input  logic [NCH-1:0] SECONDARY_OUT,
    input  logic           PWM_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] m_cfg [0:NCH-1];
    logic [7:0] m_ctl [0:NCH-1];
    logic       wr;
    logic       ie_any;
    logic       comp0;
    logic       fa;
    logic [3:0] fcnt;
    assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
    always_ff @(posedge MCLK or negedge RST_B) begin
        for (int i = 0; i < NCH; i++) begin
            if (!RST_B) begin
                m_cfg[i] <= 8'h00;
                m_ctl[i] <= 8'h00;
            end else if (wr && PADDR == 8'(i * 32)) begin
                m_cfg[i] <= PWDATA[7:0] & 8'h7f;
            end else if (wr && PADDR == 8'(i * 32 + 4)) begin
                m_ctl[i] <= PWDATA[7:0];
            end
        end
    end
    always_comb begin
        ie_any = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            ie_any = ie_any | m_ctl[i][7];
        end
    end
    // Level 11 forces both high by design, so it is kept out of the dead band check
    assign comp0 = !m_cfg[0][3] && m_ctl[0][3:2] == 2'b00 && m_cfg[0][6:5] != 2'b11;
    assign fa = m_cfg[0][4] && m_cfg[0][2:0] == 3'b111 && FAULT_PIN[0] == m_ctl[0][4];
    // Any write restarts the count, as it may change the forced levels
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            fcnt <= 4'h0;
        end else if (!fa || wr) begin
            fcnt <= 4'h0;
        end else if (fcnt != 4'hf) begin
            fcnt <= fcnt + 4'h1;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    apb_ready_a:
        assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("APB answer not a single cycle after setup");
    rd_data_a:
        assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0 && (!PSLVERR || PRDATA == 0))
        else $error("Read data upper bits or error data not zero");
    addr_err_a:
        assert property (PREADY |-> PSLVERR == (PADDR > 8'h5c || PADDR[1:0] != 2'b00))
        else $error("Slave error does not match address");
    mod_off_a:
        assert property (!m_cfg[0][0] && !$past(m_cfg[0][0]) |-> !PRIMARY_OUT[0] && !SECONDARY_OUT[0])
        else $error("Output active while module disabled");
    pri_gate_a:
        assert property (!m_cfg[0][1] && !$past(m_cfg[0][1]) |-> !PRIMARY_OUT[0])
        else $error("Primary active while its enable is clear");
    sec_gate_a:
        assert property (!m_cfg[0][2] && !$past(m_cfg[0][2]) |-> !SECONDARY_OUT[0])
        else $error("Secondary active while its enable is clear");
    irq_gate_a:
        assert property (!ie_any && !$past(ie_any) |-> !PWM_IRQ)
        else $error("Interrupt raised with all interrupt enables clear");
    fault_lvl_a:
        assert property (fcnt >= 4'h6 |-> {PRIMARY_OUT[0], SECONDARY_OUT[0]} == m_cfg[0][6:5])
        else $error("Outputs not at fault levels during fault");
    dead_band_a:
        assert property (comp0 && $past(comp0) |-> !(PRIMARY_OUT[0] && SECONDARY_OUT[0]))
        else $error("Both outputs active in complementary mode");
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the three-channel PWM pair top, driven over APB.
// Assumes the stage model on the pins and the bound property checker.
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  fault_pin;
    logic [2:0]  fault_on;
    logic [2:0]  act_hi;
    logic [2:0]  pri_out;
    logic [2:0]  sec_out;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          pri_hi;
    int          sec_hi;
    int          bad_count;
    int          num_checks;
    int          cyc;
    pwmp_top #(.NCH(3), .W(12)) dut_u (
        .MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .FAULT_PIN(fault_pin), .PRIMARY_OUT(pri_out),
        .SECONDARY_OUT(sec_out), .PWM_IRQ(irq)
    );
    pwmp_stage_model stage_u (
        .clk(mclk), .primary(pri_out), .secondary(sec_out), .fault_on(fault_on),
        .act_hi(act_hi), .fault_pin(fault_pin), .pri_hi(pri_hi), .sec_hi(sec_hi)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Windows are whole periods, so the counts do not depend on phase
    task automatic meas(input int n, output int dp, output int ds);
        int p0;
        int s0;
        repeat (4) @(posedge mclk);
        p0 = pri_hi;
        s0 = sec_hi;
        repeat (n) @(posedge mclk);
        dp = pri_hi - p0;
        ds = sec_hi - s0;
    endtask
    // High part first: the low write commits the value
    task automatic set_vals(input logic [11:0] p, input logic [11:0] u, input logic [11:0] t);
        apb(8'h0c, 1'b1, {4'h0, p[11:8]});
        apb(8'h08, 1'b1, p[7:0]);
        apb(8'h14, 1'b1, {4'h0, u[11:8]});
        apb(8'h10, 1'b1, u[7:0]);
        apb(8'h1c, 1'b1, {4'h0, t[11:8]});
        apb(8'h18, 1'b1, t[7:0]);
    endtask
    task automatic t_regs;
        for (int ch = 0; ch < 3; ch++) begin
            apb(8'(ch * 32), 1'b0, 8'h00);
            `CHK(rd, 32'h0)
            apb(8'(ch * 32 + 4), 1'b0, 8'h00);
            `CHK(rd, 32'h0)
        end
        apb(8'h60, 1'b0, 8'h00);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(8'h0c, 1'b1, 8'hff);
        apb(8'h0c, 1'b0, 8'h00);
        `CHK(rd, 32'h0f)
        apb(8'h00, 1'b1, 8'hf8);
        apb(8'h00, 1'b0, 8'h00);
        `CHK(rd, 32'h78)
        apb(8'h00, 1'b1, 8'h00);
    endtask
    task automatic t_comp;
        int dp;
        int ds;
        set_vals(12'd20, 12'd5, 12'd3);
        apb(8'h04, 1'b1, 8'h00);
        apb(8'h00, 1'b1, 8'h07);
        meas(40, dp, ds);
        `CHK(dp, 4)
        `CHK(ds, 24)
        apb(8'h00, 1'b1, 8'h05);
        meas(40, dp, ds);
        `CHK(dp, 0)
        `CHK(ds, 24)
        `CHK(pri_out[0], 1'b0)
        // A high nibble alone must not change the running period
        apb(8'h0c, 1'b1, 8'h01);
        meas(40, dp, ds);
        `CHK(ds, 24)
        apb(8'h0c, 1'b1, 8'h00);
        apb(8'h08, 1'b1, 8'h0a);
        repeat (20) @(posedge mclk);
        meas(40, dp, ds);
        `CHK(ds, 8)
        apb(8'h08, 1'b1, 8'h14);
    endtask
    task automatic t_indep;
        int dp;
        int ds;
        for (int p = 0; p < 4; p++) begin
            apb(8'h00, 1'b1, 8'h00);
            apb(8'h04, 1'b1, 8'(p << 2));
            apb(8'h00, 1'b1, 8'h0f);
            meas(40, dp, ds);
            `CHK(dp, p[1] ? 30 : 10)
            `CHK(ds, p[0] ? 34 : 6)
        end
    endtask
    task automatic t_div;
        int dp;
        int ds;
        int d;
        set_vals(12'd4, 12'd2, 12'd1);
        for (int c = 0; c < 4; c++) begin
            d = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 32 : 128;
            apb(8'h00, 1'b1, 8'h00);
            apb(8'h04, 1'b1, 8'(c));
            apb(8'h00, 1'b1, 8'h0f);
            repeat (8 * d) @(posedge mclk);
            meas(8 * d, dp, ds);
            `CHK(dp, 4 * d)
            `CHK(ds, 2 * d)
        end
    endtask
    task automatic t_fault;
        for (int c = 0; c < 4; c++) begin
            apb(8'h00, 1'b1, 8'h00);
            act_hi[0] <= c[0];
            apb(8'h04, 1'b1, {3'b000, c[0], 4'h0});
            apb(8'h00, 1'b1, 8'h17 | 8'((c << 5) | ((c & 1) << 3)));
            fault_on[0] <= 1'b1;
            repeat (24) @(posedge mclk);
            `CHK({pri_out[0], sec_out[0]}, 2'(c))
            apb(8'h04, 1'b1, {3'b000, c[0], 4'h0});
            repeat (24) @(posedge mclk);
            apb(8'h04, 1'b0, 8'h00);
            `CHK(rd[6:5], 2'b11)
            fault_on[0] <= 1'b0;
            repeat (8) @(posedge mclk);
            `CHK({pri_out[0], sec_out[0]}, 2'(c))
            apb(8'h04, 1'b1, {3'b000, c[0], 4'h0});
            apb(8'h04, 1'b0, 8'h00);
            `CHK(rd[5], 1'b0)
        end
        apb(8'h00, 1'b1, 8'h00);
        apb(8'h00, 1'b1, 8'h07);
        fault_on[0] <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(8'h04, 1'b0, 8'h00);
        `CHK(rd[5], 1'b0)
        fault_on[0] <= 1'b0;
    endtask
    task automatic t_timer;
        apb(8'h44, 1'b1, 8'h0c);
        apb(8'h40, 1'b1, 8'h0f);
        repeat (4) @(posedge mclk);
        `CHK({pri_out[2], sec_out[2]}, 2'b11)
        apb(8'h40, 1'b1, 8'h00);
        repeat (2) @(posedge mclk);
        `CHK({pri_out[2], sec_out[2]}, 2'b00)
        apb(8'h2c, 1'b1, 8'h00);
        apb(8'h28, 1'b1, 8'h05);
        apb(8'h20, 1'b1, 8'h01);
        repeat (12) @(posedge mclk);
        `CHK({irq, pri_out[1], sec_out[1]}, 3'b000)
        apb(8'h24, 1'b0, 8'h00);
        `CHK(rd[6], 1'b1)
        apb(8'h24, 1'b1, 8'hc0);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b1)
        apb(8'h20, 1'b1, 8'h00);
        apb(8'h24, 1'b1, 8'h80);
        repeat (12) @(posedge mclk);
        `CHK(irq, 1'b0)
        apb(8'h24, 1'b0, 8'h00);
        `CHK(rd, 32'h80)
    endtask
    task automatic test_done;
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Longest path is the divide by 128 window, well inside this ceiling
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fault_on = 3'b000;
        act_hi = 3'b000;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs;
        t_comp;
        t_indep;
        t_div;
        t_fault;
        t_timer;
        test_done;
    end
endmodule
bind pwmp_top pwmp_top_properties #(.NCH(NCH), .W(W)) chk_u (
    .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .FAULT_PIN(FAULT_PIN), .PRIMARY_OUT(PRIMARY_OUT),
    .SECONDARY_OUT(SECONDARY_OUT), .PWM_IRQ(PWM_IRQ)
);
